// ### hw/apr_regs.vh
// register map, field positions, reset values and timing for the alert pin two routing block
`ifndef APR_REGS_VH
`define APR_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define APR_OFS_ROUTE       8'h28
`define APR_OFS_ENABLE      8'h40
`define APR_OFS_CTRL        8'h44
`define APR_OFS_STATUS      8'h48
`define APR_OFS_MASK        8'h4C
`define APR_OFS_LIVE        8'h50

// ****************************************************************
// routing register fields
// ****************************************************************
`define APR_ROUTE_WIDTH     24
`define APR_ROUTE_OC_HI     23
`define APR_ROUTE_UC_HI     19
`define APR_ROUTE_OV_HI     15
`define APR_ROUTE_UV_HI     11
`define APR_ROUTE_OP_HI     7
`define APR_ROUTE_ACC_FULL  3
`define APR_ROUTE_CNT_FULL  2
`define APR_ROUTE_CONV_DONE 1
`define APR_ROUTE_UNIMP     0
`define APR_ROUTE_RST       24'h000000
`define APR_ROUTE_IMPL      24'hFFFFFE

// ****************************************************************
// control register fields
// ****************************************************************
`define APR_CTRL_ALERT_FN   0
`define APR_CTRL_GPIO_OUT   1
`define APR_CTRL_WIDTH      2
`define APR_CTRL_RST        2'h0
`define APR_ENABLE_RST      24'h000000

// ****************************************************************
// interrupt status and mask fields
// ****************************************************************
`define APR_IRQ_WIDTH       3
`define APR_IRQ_PIN_RISE    0
`define APR_IRQ_CONV_DONE   1
`define APR_IRQ_ACC_FULL    2
`define APR_IRQ_RST         3'h0

// ****************************************************************
// timing
// ****************************************************************
`define APR_CLK_PERIOD_NS   10
`define APR_CONV_PULSE_NS   5000
`define APR_CONV_PULSE_CYC  ((`APR_CONV_PULSE_NS + `APR_CLK_PERIOD_NS - 1) / `APR_CLK_PERIOD_NS)

`endif

// ### hw/apr_pulse.v
// retriggerable pulse stretcher for the conversion-complete alert
`timescale 1ns/10ps

module apr_pulse #(
	parameter CYCLES = 500,
	parameter CW     = 10
) (
	input  wire clk,
	input  wire rst,
	input  wire trig,
	output wire active
);

	reg  [CW-1:0] cnt_q;
	reg  [CW-1:0] cnt_d;

	// ****************************************************************
	// counter
	// ****************************************************************
	// a new conversion restarts the full width rather than extending a stale one
	always @* begin
		cnt_d = cnt_q;
		if (trig) begin
			cnt_d = CYCLES[CW-1:0];
		end else if (cnt_q != {CW{1'b0}}) begin
			cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= {CW{1'b0}};
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign active = (cnt_q != {CW{1'b0}});

endmodule

// ### hw/apr_top.v
// alert pin two routing: wishbone registers, condition qualification and pin drive
//
// Summary of operation
// - writable routing register, each set bit selects one alert for pin two.
// - routing affects pin only while pin is configured for alert function.
// - a condition reaches pin only if also globally enabled.
// - bits 23..20 route overcurrent alert of channels one to four.
// - bits 19..16 route undercurrent alert of channels one to four.
// - bits 15..12 route overvoltage alert of channels one to four.
// - bits 11..8 route undervoltage alert of channels one to four.
// - implemented routing bits read and write freely, zero after reset.
// - bit 0 unimplemented: writes ignored, reads zero.
// - bits 7..4 route overpower alert of channels one to four.
// - bit 3 routes accumulator overflow or fullness alert of any channel.
// - bit 2 routes sample counter overflow or fullness alert.
// - bit 1 pulses pin five microseconds at every conversion completion.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "apr_regs.vh"

module apr_top #(
	parameter PULSE_CYCLES = `APR_CONV_PULSE_CYC,
	parameter PULSE_CW     = 10
) (
	input  wire        REF_CLK,
	input  wire        RST,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [7:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	input  wire [3:0]  COND_OVERCURRENT,
	input  wire [3:0]  COND_UNDERCURRENT,
	input  wire [3:0]  COND_OVERVOLTAGE,
	input  wire [3:0]  COND_UNDERVOLTAGE,
	input  wire [3:0]  COND_OVERPOWER,
	input  wire        COND_ACCUMULATOR_FULL,
	input  wire        COND_SAMPLE_COUNTER_FULL,
	input  wire        CONVERSION_DONE,
	output reg         ALERT_PIN_TWO,
	output reg         IRQ
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	reg  [23:0] alert_pin2_routing_q;
	reg  [23:0] alert_enable_q;
	reg  [1:0]  ctrl_q;
	reg  [2:0]  irq_status_q;
	reg  [2:0]  irq_status_d;
	reg  [2:0]  irq_mask_q;
	reg         pin_prev_q;
	reg         acc_prev_q;
	reg  [31:0] rd_data;
	reg         rd_hit;

	wire        bus_req;
	wire        wr_en;
	wire        rd_en;
	wire [31:0] byte_mask;
	wire [31:0] wr_merge_route;
	wire [31:0] wr_merge_enable;
	wire [31:0] wr_merge_ctrl;
	wire [31:0] wr_merge_mask;
	wire [23:0] cond_vec;
	wire [23:0] qualified;
	wire        any_alert;
	wire        conv_active;
	wire        pin_next;
	wire        alert_fn;
	wire [2:0]  irq_events;

	// ****************************************************************
	// condition vector
	// ****************************************************************
	// channel one sits at the highest bit of each nibble
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_chan
			assign cond_vec[`APR_ROUTE_OC_HI - g] = COND_OVERCURRENT[g];
			assign cond_vec[`APR_ROUTE_UC_HI - g] = COND_UNDERCURRENT[g];
			assign cond_vec[`APR_ROUTE_OV_HI - g] = COND_OVERVOLTAGE[g];
			assign cond_vec[`APR_ROUTE_UV_HI - g] = COND_UNDERVOLTAGE[g];
			assign cond_vec[`APR_ROUTE_OP_HI - g] = COND_OVERPOWER[g];
		end
	endgenerate

	assign cond_vec[`APR_ROUTE_ACC_FULL]  = COND_ACCUMULATOR_FULL;
	assign cond_vec[`APR_ROUTE_CNT_FULL]  = COND_SAMPLE_COUNTER_FULL;
	assign cond_vec[`APR_ROUTE_CONV_DONE] = conv_active;
	assign cond_vec[`APR_ROUTE_UNIMP]     = 1'b0;

	// ****************************************************************
	// conversion-complete pulse
	// ****************************************************************
	// the pulse runs whatever the routing bit says; routing only gates the pin
	apr_pulse #(
		.CYCLES (PULSE_CYCLES),
		.CW     (PULSE_CW)
	) u_conv_pulse (
		.clk    (REF_CLK),
		.rst    (RST),
		.trig   (CONVERSION_DONE),
		.active (conv_active)
	);

	// ****************************************************************
	// qualification and pin drive
	// ****************************************************************
	assign qualified = cond_vec & alert_enable_q & alert_pin2_routing_q;
	assign any_alert = |qualified;
	assign alert_fn  = ctrl_q[`APR_CTRL_ALERT_FN];

	// outside alert function the pin follows the plain output bit only
	assign pin_next = alert_fn ? any_alert : ctrl_q[`APR_CTRL_GPIO_OUT];

	always @(posedge REF_CLK) begin
		if (RST) begin
			ALERT_PIN_TWO <= 1'b0;
		end else begin
			ALERT_PIN_TWO <= pin_next;
		end
	end

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	// every access answers one cycle after the strobe; ack drops the cycle after
	assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	// a write lands on the edge at which the master sees ack, never earlier
	assign wr_en   = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I;
	assign rd_en   = bus_req & ~WB_WE_I;

	assign byte_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

	assign wr_merge_route  = ({8'h00, alert_pin2_routing_q} & ~byte_mask) | (WB_DAT_I & byte_mask);
	assign wr_merge_enable = ({8'h00, alert_enable_q} & ~byte_mask) | (WB_DAT_I & byte_mask);
	assign wr_merge_ctrl   = ({30'h00000000, ctrl_q} & ~byte_mask) | (WB_DAT_I & byte_mask);
	assign wr_merge_mask   = ({29'h00000000, irq_mask_q} & ~byte_mask) | (WB_DAT_I & byte_mask);

	always @(posedge REF_CLK) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= bus_req;
		end
	end

	// ****************************************************************
	// writable registers
	// ****************************************************************
	always @(posedge REF_CLK) begin
		if (RST) begin
			alert_pin2_routing_q <= `APR_ROUTE_RST;
		end else if (wr_en && WB_ADR_I == `APR_OFS_ROUTE) begin
			// bit 0 has no storage behind it
			alert_pin2_routing_q <= wr_merge_route[23:0] & `APR_ROUTE_IMPL;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			alert_enable_q <= `APR_ENABLE_RST;
		end else if (wr_en && WB_ADR_I == `APR_OFS_ENABLE) begin
			alert_enable_q <= wr_merge_enable[23:0] & `APR_ROUTE_IMPL;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			ctrl_q <= `APR_CTRL_RST;
		end else if (wr_en && WB_ADR_I == `APR_OFS_CTRL) begin
			ctrl_q <= wr_merge_ctrl[1:0];
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			irq_mask_q <= `APR_IRQ_RST;
		end else if (wr_en && WB_ADR_I == `APR_OFS_MASK) begin
			irq_mask_q <= wr_merge_mask[2:0];
		end
	end

	// ****************************************************************
	// interrupt events
	// ****************************************************************
	always @(posedge REF_CLK) begin
		if (RST) begin
			pin_prev_q <= 1'b0;
			acc_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= ALERT_PIN_TWO;
			acc_prev_q <= COND_ACCUMULATOR_FULL;
		end
	end

	assign irq_events[`APR_IRQ_PIN_RISE]  = ALERT_PIN_TWO & ~pin_prev_q;
	assign irq_events[`APR_IRQ_CONV_DONE] = CONVERSION_DONE;
	assign irq_events[`APR_IRQ_ACC_FULL]  = COND_ACCUMULATOR_FULL & ~acc_prev_q;

	// a read clears the status, but an event in the same cycle survives it
	always @* begin
		irq_status_d = irq_status_q;
		if (rd_en && WB_ADR_I == `APR_OFS_STATUS) begin
			irq_status_d = `APR_IRQ_RST;
		end
		irq_status_d = irq_status_d | irq_events;
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			irq_status_q <= `APR_IRQ_RST;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_status_d & irq_mask_q);
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	// unmapped addresses still acknowledge and return zero
	always @* begin
		rd_data = 32'h00000000;
		rd_hit  = 1'b1;
		case (WB_ADR_I)
			`APR_OFS_ROUTE: begin
				rd_data = {8'h00, alert_pin2_routing_q & `APR_ROUTE_IMPL};
			end
			`APR_OFS_ENABLE: begin
				rd_data = {8'h00, alert_enable_q};
			end
			`APR_OFS_CTRL: begin
				rd_data = {30'h00000000, ctrl_q};
			end
			`APR_OFS_STATUS: begin
				rd_data = {29'h00000000, irq_status_q};
			end
			`APR_OFS_MASK: begin
				rd_data = {29'h00000000, irq_mask_q};
			end
			`APR_OFS_LIVE: begin
				// live conditions in routing layout, pin level in bit 0
				rd_data = {8'h00, cond_vec[23:1], ALERT_PIN_TWO};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			WB_DAT_O <= 32'h00000000;
		end else if (rd_en) begin
			WB_DAT_O <= rd_hit ? rd_data : 32'h00000000;
		end else begin
			WB_DAT_O <= 32'h00000000;
		end
	end

endmodule

// ### bench/apr_asserts.sv
// concurrent checks on the register bus and the pin of the routing block
`timescale 1ns/10ps
module apr_asserts (
	input logic        REF_CLK,
	input logic        RST,
	input logic        WB_CYC_I,
	input logic        WB_STB_I,
	input logic        WB_WE_I,
	input logic [7:0]  WB_ADR_I,
	input logic [31:0] WB_DAT_O,
	input logic        WB_ACK_O,
	input logic        ALERT_PIN_TWO,
	input logic        IRQ
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
	AST_ACK_TAKE: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
	AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("stray ack");
	AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data outside ack");
	AST_TOP_ZERO: assert property (WB_ACK_O |-> WB_DAT_O[31:24] == 8'h00) else $error("upper byte set");
	AST_BIT0_ZERO: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I == 8'h28) |-> !WB_DAT_O[0])
		else $error("route bit 0 reads one");
	AST_UNMAPPED: assert property (WB_ACK_O && $past(WB_ADR_I == 8'h7C) |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	// reset itself is the cause here, so the default disable is overridden
	AST_RST_OUT: assert property (disable iff (1'h0) RST |=> !WB_ACK_O && !ALERT_PIN_TWO && !IRQ)
		else $error("outputs not cleared by reset");
endmodule
bind apr_top apr_asserts u_chk (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.ALERT_PIN_TWO(ALERT_PIN_TWO), .IRQ(IRQ));

// ### bench/apr_cond_src.sv
// model of the measurement front end that raises the alert conditions
`timescale 1ns/10ps
module apr_cond_src (
	input  logic        clk,
	input  logic [23:2] vec,
	input  logic        conv,
	output logic [3:0]  oc,
	output logic [3:0]  uc,
	output logic [3:0]  ov,
	output logic [3:0]  uv,
	output logic [3:0]  op,
	output logic        af,
	output logic        sf,
	output logic        cd
);
	logic conv_q = 1'h0;
	always @(posedge clk) conv_q <= conv;
	// a held request still gives one pulse, as a real conversion end would
	assign cd = conv & !conv_q;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			oc[i] = vec[23 - i];
			uc[i] = vec[19 - i];
			ov[i] = vec[15 - i];
			uv[i] = vec[11 - i];
			op[i] = vec[7 - i];
		end
		af = vec[3];
		sf = vec[2];
	end
endmodule

// ### bench/apr_top_tb.sv
// self-checking bench for the alert pin two routing block
`timescale 1ns/10ps
`include "apr_regs.vh"
module apr_top_tb;
	logic        clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, conv = 1'h0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dw = 32'h0, q, dr, seed = 32'h145282C5, n;
	logic [23:0] c = 24'h0, r, e;
	logic [3:0]  oc, uc, ov, uv, op;
	logic        af, sf, cd, ack, pin, irq;
	int          err_total = 0, check_count = 0;
	always #5 clk = ~clk;
	apr_cond_src src (.clk(clk), .vec(c[23:2]), .conv(conv), .oc(oc), .uc(uc), .ov(ov), .uv(uv), .op(op),
		.af(af), .sf(sf), .cd(cd));
	apr_top #(.PULSE_CYCLES(`APR_CONV_PULSE_CYC), .PULSE_CW(10)) dut (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc),
		.WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
		.COND_OVERCURRENT(oc), .COND_UNDERCURRENT(uc), .COND_OVERVOLTAGE(ov), .COND_UNDERVOLTAGE(uv),
		.COND_OVERPOWER(op), .COND_ACCUMULATOR_FULL(af), .COND_SAMPLE_COUNTER_FULL(sf),
		.CONVERSION_DONE(cd), .ALERT_PIN_TWO(pin), .IRQ(irq));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dw <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'h1 && k < 20);
		if (ack !== 1'h1) err_total++;
		q = dr;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	// one conversion end, then count the cycles the pin stays up
	task automatic conv_pulse;
		conv <= 1'h1;
		@(posedge clk);
		conv <= 1'h0;
		n = 0;
		repeat (`APR_CONV_PULSE_CYC + 7) begin
			@(posedge clk);
			n += pin;
		end
	endtask
	initial begin
		#100000;
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		wb(0, `APR_OFS_ROUTE, 0);
		chk(q, 32'h0);
		wb(1, `APR_OFS_ROUTE, 32'hFFFFFFFF);
		wb(0, `APR_OFS_ROUTE, 0);
		chk(q, 32'h00FFFFFE);
		wb(0, 8'h7C, 0);
		chk(q, 32'h0);
		c <= 24'hFFFFFC;
		wb(1, `APR_OFS_ENABLE, 32'hFFFFFF);
		wb(0, `APR_OFS_ENABLE, 0);
		chk(q, 32'h00FFFFFE);
		wb(1, `APR_OFS_CTRL, 32'h2);
		repeat (2) @(posedge clk);
		chk(pin, 1'h1);
		wb(0, `APR_OFS_LIVE, 0);
		chk(q, 32'h00FFFFFD);
		wb(1, `APR_OFS_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk(pin, 1'h0);
		wb(1, `APR_OFS_CTRL, 32'h1);
		// early passes route one bit with every other condition up, so a crossed bit shows
		for (int i = 0; i < 70; i++) begin
			seed = lfsr(seed);
			r = (i < 22) ? 24'h1 << (i + 2) : seed[23:0];
			seed = lfsr(seed);
			e = (i < 22) ? 24'hFFFFFF : seed[23:0];
			seed = lfsr(seed);
			// conditions move only while the global enable is off
			wb(1, `APR_OFS_ENABLE, 32'h0);
			c <= ((i < 22) ? ~r : seed[23:0]) & 24'hFFFFFC;
			wb(1, `APR_OFS_ROUTE, {8'h0, r});
			wb(0, `APR_OFS_ROUTE, 0);
			chk(q, {8'h0, r & `APR_ROUTE_IMPL});
			wb(1, `APR_OFS_ENABLE, {8'h0, e});
			repeat (2) @(posedge clk);
			chk(pin, |(r & e & c & `APR_ROUTE_IMPL));
		end
		c <= 24'h0;
		wb(1, `APR_OFS_ROUTE, 32'h2);
		wb(1, `APR_OFS_ENABLE, 32'h2);
		wb(1, `APR_OFS_MASK, 32'h7);
		wb(0, `APR_OFS_STATUS, 0);
		@(posedge clk);
		chk(irq, 1'h0);
		conv_pulse();
		chk(n, `APR_CONV_PULSE_CYC);
		chk(irq, 1'h1);
		wb(0, `APR_OFS_STATUS, 0);
		chk(q, 32'h3);
		@(posedge clk);
		chk(irq, 1'h0);
		wb(1, `APR_OFS_ROUTE, 32'h0);
		wb(1, `APR_OFS_MASK, 32'h0);
		conv_pulse();
		chk(n, 0);
		chk(irq, 1'h0);
		wb(0, `APR_OFS_STATUS, 0);
		chk(q, 32'h2);
		c <= 24'h000008;
		repeat (2) @(posedge clk);
		wb(0, `APR_OFS_STATUS, 0);
		chk(q, 32'h4);
		print_verdict();
	end
endmodule
